// File: core/pfts_map.svh
`ifndef PFTS_MAP_SVH
`define PFTS_MAP_SVH

// ==========================================================
// queue status encodings, instruction type and flush slots
`define PFTS_QS_NONE 3'h0
`define PFTS_QS_SEQ 3'h1
`define PFTS_QS_NT 3'h2
`define PFTS_QS_SYNC 3'h3
`define PFTS_QS_EXC 3'h4
`define PFTS_QS_IND 3'h5
`define PFTS_QS_DIR 3'h6
`define PFTS_QS_NT_LATE 3'h7
`define PFTS_QS_MAX_FLUSH 3'h5

// ==========================================================
// history flush status encodings
`define PFTS_HF_NONE 2'h0
`define PFTS_HF_MAX 2'h2
`define PFTS_HF_DEBUG 2'h3

// ==========================================================
// cycle kind encodings
`define PFTS_CK_EXT 4'h0
`define PFTS_CK_EXT_MARK 4'h1
`define PFTS_CK_EMUL 4'h2
`define PFTS_CK_PORT 4'h3
`define PFTS_CK_IBUS 4'h4
`define PFTS_CK_LBUS 4'h5
`define PFTS_CK_HIT_NOCS 4'h6
`define PFTS_CK_REG 4'h7
`define PFTS_CK_HIT_BOOT 4'h8

// ==========================================================
// fetch show select encodings
`define PFTS_FSS_ALL 2'h0
`define PFTS_FSS_COF 2'h1
`define PFTS_FSS_IND 2'h2
`define PFTS_FSS_NONE 2'h3
`define PFTS_FSS_RESET 2'h0

// ==========================================================
// register map, byte addresses
`define PFTS_ADDR_CTRL 12'h000
`define PFTS_ADDR_STATUS 12'h004
`define PFTS_CTRL_FSS_LSB 0
`define PFTS_CTRL_FSS_MSB 1
`define PFTS_ST_SYNC 0
`define PFTS_ST_DEBUG 1
`define PFTS_ST_SYNC_PEND 2
`define PFTS_ST_MARK_PEND 3
`define PFTS_ST_QS_LSB 4
`define PFTS_ST_QS_MSB 6
`define PFTS_ST_HF_LSB 8
`define PFTS_ST_HF_MSB 9

`endif

// File: core/pfts_pkg.sv
package pfts_pkg;

	// ==========================================================
	// instruction type reported by the core this cycle
	typedef enum logic [2:0]
	{
		PFTS_IT_NONE = 3'h0,
		PFTS_IT_SEQ = 3'h1,
		PFTS_IT_NT = 3'h2,
		PFTS_IT_EXC = 3'h3,
		PFTS_IT_IND = 3'h4,
		PFTS_IT_DIR = 3'h5
	} pfts_itype_t;

	// ==========================================================
	// where a bus or show cycle goes
	typedef enum logic [2:0]
	{
		PFTS_SRC_EXT = 3'h0,
		PFTS_SRC_EMUL = 3'h1,
		PFTS_SRC_PORT = 3'h2,
		PFTS_SRC_IBUS = 3'h3,
		PFTS_SRC_LBUS = 3'h4,
		PFTS_SRC_HIT = 3'h5,
		PFTS_SRC_REG = 3'h6
	} pfts_src_t;

	// ==========================================================
	// queue status slot tracker
	typedef enum logic [1:0]
	{
		PFTS_ST_TYPE = 2'b00,
		PFTS_ST_FLUSH = 2'b01,
		PFTS_ST_DEBUG = 2'b10
	} pfts_state_t;

endpackage

// File: core/pfts_trace_status.sv
// Behaviour
// - late not-taken 111 may fill flush slot
// - history flush pins carry flushed count, saturated at 10
// - history value 11 only means debug
// - debug mode: queue 000, history 11
// - sync change in debug reported first
// - otherwise first report after debug 101
// - first fetch after debug is marked
// - cycle kinds 0000, 0011, 0111 encoded
// - 0001 reservation or external indirect target
// - 0010 emulation, 0100 ibus, 0101 lbus
// - cache hits 0110, 1000 to 1101
// - internal indirect fetch drives direction low
// - sync toggled in debug reports 011
// - sync change gives 011, marks next
// - flush counts 000 to 101, 110 reserved
// - sync flag comes from development port
`timescale 1ns/1ps
`include "pfts_map.svh"

module pfts_trace_status
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// core status, same clock
	input wire logic debug_mode,
	input wire logic sync_flag,
	input wire logic [2:0] instr_type,
	input wire logic flush_valid,
	input wire logic [2:0] flush_count,
	input wire logic [1:0] history_flush_count,
	// fetch show decision
	input wire logic fetch_cof_direct,
	input wire logic fetch_cof_indirect,
	output logic show_fetch,
	// bus cycle classification
	input wire logic cycle_valid,
	input wire logic [2:0] cycle_source,
	input wire logic [2:0] cycle_chip_select,
	input wire logic cycle_is_instr,
	input wire logic cycle_is_write,
	input wire logic cycle_reserve,
	input wire logic cycle_indirect,
	// trace pins
	output logic [2:0] queue_status,
	output logic [1:0] history_flush_status,
	output logic [3:0] cycle_kind,
	output logic address_kind_instruction,
	output logic write_read_n
);

	// ==========================================================
	// state
	pfts_pkg::pfts_state_t state_reg;
	pfts_pkg::pfts_state_t state_next;
	logic [2:0] qs_next;
	logic [1:0] fss_reg;
	logic sync_last_reg;
	logic sync_entry_reg;
	logic sync_pend_reg;
	logic mark_pend_reg;
	logic sync_emit;
	logic debug_exit;
	logic fetch_now;
	logic wr_access;
	logic rd_setup;
	logic addr_ok;

	// ==========================================================
	// helpers
	function automatic logic [3:0] kind_of(input logic [2:0] src, input logic [2:0] cs,
		input logic instr, input logic resv, input logic ind);
		logic [3:0] k;
		k = `PFTS_CK_EXT;
		case (src)
			pfts_pkg::PFTS_SRC_EXT:
				if ((instr && ind) || (!instr && resv))
					k = `PFTS_CK_EXT_MARK;
			pfts_pkg::PFTS_SRC_EMUL: k = `PFTS_CK_EMUL;
			pfts_pkg::PFTS_SRC_IBUS: k = `PFTS_CK_IBUS;
			pfts_pkg::PFTS_SRC_LBUS: k = `PFTS_CK_LBUS;
			pfts_pkg::PFTS_SRC_PORT: k = `PFTS_CK_PORT;
			pfts_pkg::PFTS_SRC_REG: k = `PFTS_CK_REG;
			pfts_pkg::PFTS_SRC_HIT:
				if (cs == 3'h0)
					k = `PFTS_CK_HIT_NOCS;
				else if (cs <= 3'h6)
					k = `PFTS_CK_HIT_BOOT + {1'b0, cs - 3'h1};
				else
					k = `PFTS_CK_HIT_NOCS;
			default: k = `PFTS_CK_EXT;
		endcase
		return k;
	endfunction

	function automatic logic is_show_src(input logic [2:0] src);
		return src == pfts_pkg::PFTS_SRC_EMUL || src == pfts_pkg::PFTS_SRC_IBUS ||
			src == pfts_pkg::PFTS_SRC_LBUS || src == pfts_pkg::PFTS_SRC_HIT;
	endfunction

	// ==========================================================
	// apb slave, zero wait states
	assign pready = 1'b1;
	assign addr_ok = paddr == `PFTS_ADDR_CTRL || paddr == `PFTS_ADDR_STATUS;
	assign pslverr = psel && penable && !addr_ok;
	assign wr_access = psel && penable && pwrite && paddr == `PFTS_ADDR_CTRL;
	assign rd_setup = psel && !penable && !pwrite;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			fss_reg <= `PFTS_FSS_RESET;
		else if (wr_access)
			fss_reg <= pwdata[`PFTS_CTRL_FSS_MSB:`PFTS_CTRL_FSS_LSB];
	end

	// read data captured in setup so the access phase sees a flop
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata <= 32'h0000_0000;
		else if (rd_setup)
		begin
			prdata <= 32'h0000_0000;
			if (paddr == `PFTS_ADDR_CTRL)
				prdata[`PFTS_CTRL_FSS_MSB:`PFTS_CTRL_FSS_LSB] <= fss_reg;
			else if (paddr == `PFTS_ADDR_STATUS)
			begin
				prdata[`PFTS_ST_SYNC] <= sync_flag;
				prdata[`PFTS_ST_DEBUG] <= debug_mode;
				prdata[`PFTS_ST_SYNC_PEND] <= sync_pend_reg;
				prdata[`PFTS_ST_MARK_PEND] <= mark_pend_reg;
				prdata[`PFTS_ST_QS_MSB:`PFTS_ST_QS_LSB] <= queue_status;
				prdata[`PFTS_ST_HF_MSB:`PFTS_ST_HF_LSB] <= history_flush_status;
			end
		end
	end

	// ==========================================================
	// fetch show decision
	// a marked fetch must reach the pins whatever the select says
	always_comb
	begin
		case (fss_reg)
			`PFTS_FSS_ALL: show_fetch = 1'b1;
			`PFTS_FSS_COF: show_fetch = fetch_cof_direct || fetch_cof_indirect;
			`PFTS_FSS_IND: show_fetch = fetch_cof_indirect;
			`PFTS_FSS_NONE: show_fetch = sync_flag && fetch_cof_indirect;
			default: show_fetch = 1'b1;
		endcase
		if (mark_pend_reg)
			show_fetch = 1'b1;
	end

	// ==========================================================
	// sync flag tracking
	// flag arrives from port logic
	assign debug_exit = state_reg == pfts_pkg::PFTS_ST_DEBUG && !debug_mode;
	assign fetch_now = cycle_valid && cycle_is_instr;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			sync_last_reg <= 1'b0;
		else
			sync_last_reg <= sync_flag;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			sync_entry_reg <= 1'b0;
		else if (debug_mode && state_reg != pfts_pkg::PFTS_ST_DEBUG)
			sync_entry_reg <= sync_last_reg;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			sync_pend_reg <= 1'b0;
		else if (!debug_mode && state_reg != pfts_pkg::PFTS_ST_DEBUG &&
			sync_flag != sync_last_reg)
			sync_pend_reg <= 1'b1;
		else if (sync_emit || debug_exit)
			sync_pend_reg <= 1'b0;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			mark_pend_reg <= 1'b0;
		else if (sync_emit || debug_exit)
			mark_pend_reg <= 1'b1;
		else if (fetch_now)
			mark_pend_reg <= 1'b0;
	end

	// ==========================================================
	// queue status slot
	always_comb
	begin
		state_next = state_reg;
		qs_next = `PFTS_QS_NONE;
		sync_emit = 1'b0;
		case (state_reg)
			pfts_pkg::PFTS_ST_TYPE:
				case (instr_type)
					pfts_pkg::PFTS_IT_SEQ: qs_next = `PFTS_QS_SEQ;
					pfts_pkg::PFTS_IT_NT: qs_next = `PFTS_QS_NT;
					pfts_pkg::PFTS_IT_EXC:
					begin
						qs_next = `PFTS_QS_EXC;
						state_next = pfts_pkg::PFTS_ST_FLUSH;
					end
					pfts_pkg::PFTS_IT_IND:
					begin
						qs_next = `PFTS_QS_IND;
						state_next = pfts_pkg::PFTS_ST_FLUSH;
					end
					pfts_pkg::PFTS_IT_DIR:
					begin
						qs_next = `PFTS_QS_DIR;
						state_next = pfts_pkg::PFTS_ST_FLUSH;
					end
					default:
						if (sync_pend_reg)
						begin
							qs_next = `PFTS_QS_SYNC;
							sync_emit = 1'b1;
						end
				endcase
			pfts_pkg::PFTS_ST_FLUSH:
				if (!flush_valid && instr_type == pfts_pkg::PFTS_IT_NT)
					qs_next = `PFTS_QS_NT_LATE;
				else
				begin
					if (flush_valid)
						qs_next = (flush_count > `PFTS_QS_MAX_FLUSH) ?
							`PFTS_QS_MAX_FLUSH : flush_count;
					state_next = pfts_pkg::PFTS_ST_TYPE;
				end
			pfts_pkg::PFTS_ST_DEBUG:
				if (!debug_mode)
				begin
					if (sync_flag != sync_entry_reg)
					begin
						qs_next = `PFTS_QS_SYNC;
						state_next = pfts_pkg::PFTS_ST_TYPE;
					end
					else
					begin
						qs_next = `PFTS_QS_IND;
						state_next = pfts_pkg::PFTS_ST_FLUSH;
					end
				end
			default: state_next = pfts_pkg::PFTS_ST_TYPE;
		endcase
		if (debug_mode)
		begin
			qs_next = `PFTS_QS_NONE;
			sync_emit = 1'b0;
			state_next = pfts_pkg::PFTS_ST_DEBUG;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_reg <= pfts_pkg::PFTS_ST_TYPE;
			queue_status <= `PFTS_QS_NONE;
		end
		else
		begin
			state_reg <= state_next;
			queue_status <= qs_next;
		end
	end

	// ==========================================================
	// history flush status
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			history_flush_status <= `PFTS_HF_NONE;
		else if (debug_mode)
			history_flush_status <= `PFTS_HF_DEBUG;
		else if (history_flush_count > `PFTS_HF_MAX)
			history_flush_status <= `PFTS_HF_MAX;
		else
			history_flush_status <= history_flush_count;
	end

	// ==========================================================
	// cycle classification pins
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cycle_kind <= `PFTS_CK_EXT;
			address_kind_instruction <= 1'b0;
			write_read_n <= 1'b1;
		end
		else if (cycle_valid)
		begin
			cycle_kind <= kind_of(cycle_source, cycle_chip_select, cycle_is_instr,
				cycle_reserve, cycle_indirect || (cycle_is_instr && mark_pend_reg));
			address_kind_instruction <= cycle_is_instr;
			if (cycle_is_instr)
				write_read_n <= !(is_show_src(cycle_source) &&
					(cycle_indirect || mark_pend_reg));
			else
				write_read_n <= !cycle_is_write;
		end
		else
		begin
			cycle_kind <= `PFTS_CK_EXT;
			address_kind_instruction <= 1'b0;
			write_read_n <= 1'b1;
		end
	end

endmodule

// File: verification/pfts_capture_model.sv
`timescale 1ns/1ps
module pfts_capture_model
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// observed trace pins
	input wire logic [2:0] queue_status,
	input wire logic [1:0] history_flush_status,
	// qualified sync reports
	output logic [3:0] sync_seen
);
	logic [2:0] last_qs;

	// qualify sync report
	// halted cycles carry no flow info, so they never become last_qs
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			last_qs <= 3'h0;
			sync_seen <= 4'h0;
		end
		else if (history_flush_status != 2'h3)
		begin
			last_qs <= queue_status;
			if (queue_status == 3'h3 && last_qs <= 3'h2)
				sync_seen <= sync_seen + 4'h1;
		end
endmodule

// File: verification/pfts_trace_status_properties.sv
`timescale 1ns/1ps
module pfts_trace_status_properties
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// core status
	input wire logic debug_mode,
	input wire logic [2:0] instr_type,
	input wire logic [1:0] history_flush_count,
	// bus cycle inputs
	input wire logic cycle_valid,
	input wire logic [2:0] cycle_source,
	input wire logic [2:0] cycle_chip_select,
	input wire logic cycle_is_instr,
	input wire logic cycle_reserve,
	input wire logic cycle_indirect,
	// trace pins
	input wire logic [2:0] queue_status,
	input wire logic [1:0] history_flush_status,
	input wire logic [3:0] cycle_kind,
	input wire logic address_kind_instruction,
	input wire logic write_read_n
);
	default clocking @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	a_debug_pins_held:
		assert property (debug_mode |=> queue_status == 3'h0 && history_flush_status == 2'h3)
		else $error("debug pins wrong");
	a_hist_count_follows:
		assert property (!debug_mode && history_flush_count != 2'h3
			|=> history_flush_status == $past(history_flush_count))
		else $error("history count wrong");
	a_hist_debug_only:
		assert property (history_flush_status == 2'h3 |-> $past(debug_mode))
		else $error("history 11 outside debug");
	a_exit_report_kind:
		assert property (debug_mode ##1 (!debug_mode && instr_type == 3'h0)
			|=> queue_status inside {3'h3, 3'h5})
		else $error("exit report wrong");
	a_kind_internal_mem:
		assert property (cycle_valid && cycle_source inside {3'h1, 3'h3, 3'h4}
			|=> cycle_kind == ($past(cycle_source) == 3'h1 ? 4'h2 : $past(cycle_source) + 4'h1))
		else $error("internal kind wrong");
	a_kind_cache_hit:
		assert property (cycle_valid && cycle_source == 3'h5 |=> cycle_kind ==
			($past(cycle_chip_select) == 3'h0 ? 4'h6 : 4'h7 + $past(cycle_chip_select)))
		else $error("hit kind wrong");
	a_reserve_start:
		assert property (cycle_valid && cycle_source == 3'h0 && !cycle_is_instr && cycle_reserve
			|=> cycle_kind == 4'h1 && !address_kind_instruction)
		else $error("reservation kind wrong");
	a_indirect_dir_low:
		assert property (cycle_valid && cycle_is_instr && cycle_indirect
			&& cycle_source inside {3'h1, 3'h3, 3'h4, 3'h5}
			|=> !write_read_n && address_kind_instruction)
		else $error("indirect mark missing");
endmodule

bind pfts_trace_status pfts_trace_status_properties chk
(
	.pclk(pclk),
	.presetn(presetn),
	.debug_mode(debug_mode),
	.instr_type(instr_type),
	.history_flush_count(history_flush_count),
	.cycle_valid(cycle_valid),
	.cycle_source(cycle_source),
	.cycle_chip_select(cycle_chip_select),
	.cycle_is_instr(cycle_is_instr),
	.cycle_reserve(cycle_reserve),
	.cycle_indirect(cycle_indirect),
	.queue_status(queue_status),
	.history_flush_status(history_flush_status),
	.cycle_kind(cycle_kind),
	.address_kind_instruction(address_kind_instruction),
	.write_read_n(write_read_n)
);

// File: verification/pfts_trace_status_tb.sv
`timescale 1ns/1ps
module pfts_trace_status_tb;
	// ====================
	// signals
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic debug_mode, sync_flag, flush_valid, fetch_cof_direct, fetch_cof_indirect, show_fetch;
	logic cycle_valid, cycle_is_instr, cycle_is_write, cycle_reserve, cycle_indirect;
	logic [2:0] instr_type, flush_count, cycle_source, cycle_chip_select, queue_status, r;
	logic [1:0] history_flush_count, history_flush_status, h;
	logic [3:0] cycle_kind, sync_seen;
	logic address_kind_instruction, write_read_n;
	int num_errors, samples_checked, cyc, seed, i;
	typedef struct {int due; int sel; logic [31:0] exp;} pfts_note_t;
	pfts_note_t notes[$];

	pfts_trace_status dut
	(
		.pclk(pclk),
		.presetn(presetn),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.debug_mode(debug_mode),
		.sync_flag(sync_flag),
		.instr_type(instr_type),
		.flush_valid(flush_valid),
		.flush_count(flush_count),
		.history_flush_count(history_flush_count),
		.fetch_cof_direct(fetch_cof_direct),
		.fetch_cof_indirect(fetch_cof_indirect),
		.show_fetch(show_fetch),
		.cycle_valid(cycle_valid),
		.cycle_source(cycle_source),
		.cycle_chip_select(cycle_chip_select),
		.cycle_is_instr(cycle_is_instr),
		.cycle_is_write(cycle_is_write),
		.cycle_reserve(cycle_reserve),
		.cycle_indirect(cycle_indirect),
		.queue_status(queue_status),
		.history_flush_status(history_flush_status),
		.cycle_kind(cycle_kind),
		.address_kind_instruction(address_kind_instruction),
		.write_read_n(write_read_n)
	);
	pfts_capture_model cap
	(
		.pclk(pclk),
		.presetn(presetn),
		.queue_status(queue_status),
		.history_flush_status(history_flush_status),
		.sync_seen(sync_seen)
	);

	initial
	begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end

	// ====================
	// tasks
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		samples_checked++;
		if (s !== e)
		begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", n, e, s);
		end
	endtask

	task automatic summarize;
		if (num_errors == 0 && samples_checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic note(input int sel, input logic [31:0] e, input int off);
		notes.push_back('{cyc + off, sel, e});
	endtask

	task automatic drv(input logic [2:0] it, input logic fv, input logic [2:0] fc,
		input logic [1:0] hc, input logic dm, input logic cv);
		@(posedge pclk);
		instr_type <= it;
		flush_valid <= fv;
		flush_count <= fc;
		history_flush_count <= hc;
		debug_mode <= dm;
		cycle_valid <= cv;
	endtask

	task automatic bus(input logic [2:0] s, input logic [2:0] cs, input logic ins,
		input logic rv, input logic ind, input logic [3:0] eck, input logic ewr);
		logic w;
		drv(0, 0, 0, 0, 0, 1);
		// fetches are reads, so only data cycles get a random direction
		w = !ins && 1'($random(seed));
		cycle_source <= s;
		cycle_chip_select <= cs;
		cycle_is_instr <= ins;
		cycle_reserve <= rv;
		cycle_indirect <= ind;
		cycle_is_write <= w;
		note(2, eck, 2);
		note(3, ins ? ewr : !w, 2);
		note(8, ins, 2);
	endtask

	task automatic halt(input logic tog);
		repeat (3)
		begin
			drv(1, 0, 0, 2, 1, 0);
			note(0, 0, 2);
			note(1, 3, 2);
		end
		if (tog)
			sync_flag <= !sync_flag;
		drv(0, 0, 0, 0, 0, 0);
		note(0, tog ? 3 : 5, 2);
		drv(0, 1, 0, 0, 0, 0);
		note(0, 0, 2);
	endtask

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		input logic [31:0] e, input logic er);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		note(5, er, 1);
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		// read data stands until the next read setup, so look after the access edge
		if (!w)
			note(4, e, 1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic fetch(input logic d, input logic ind, input logic e);
		@(posedge pclk);
		fetch_cof_direct <= d;
		fetch_cof_indirect <= ind;
		note(6, e, 1);
	endtask

	// ====================
	// monitor and timeout
	always @(negedge pclk)
		while (notes.size() > 0 && notes[0].due == cyc)
		begin
			case (notes[0].sel)
				0: chk("queue_status", queue_status, notes[0].exp);
				1: chk("history_flush_status", history_flush_status, notes[0].exp);
				2: chk("cycle_kind", cycle_kind, notes[0].exp);
				3: chk("write_read_n", write_read_n, notes[0].exp);
				4: chk("prdata", prdata, notes[0].exp);
				5: chk("pslverr", pslverr, notes[0].exp);
				6: chk("show_fetch", show_fetch, notes[0].exp);
				7: chk("sync_seen", sync_seen, notes[0].exp);
				default: chk("address_kind_instruction", address_kind_instruction, notes[0].exp);
			endcase
			void'(notes.pop_front());
		end

	always @(posedge pclk)
	begin
		cyc <= cyc + 1;
		if (cyc == 2000)
		begin
			num_errors++;
			summarize();
		end
	end

	// ====================
	// sequence
	initial
	begin
		seed = 61;
		presetn = 1'b0;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{debug_mode, sync_flag, flush_valid, flush_count, instr_type} = '0;
		{history_flush_count, fetch_cof_direct, fetch_cof_indirect, cycle_valid} = '0;
		{cycle_source, cycle_chip_select, cycle_is_instr} = '0;
		{cycle_is_write, cycle_reserve, cycle_indirect} = '0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		note(0, 0, 1);
		note(1, 0, 1);
		note(3, 1, 1);
		fetch(0, 0, 1);
		for (i = 0; i < 24; i++)
		begin
			r = 3'($unsigned($random(seed)) % 3);
			h = 2'($unsigned($random(seed)) % 3);
			drv(r, 0, 0, h, 0, 0);
			note(0, r, 2);
			note(1, h, 2);
		end
		for (i = 0; i < 6; i++)
		begin
			drv(3'(3 + i % 3), 0, 0, 0, 0, 0);
			note(0, 4 + i % 3, 2);
			drv(0, 1, 3'(i), 0, 0, 0);
			note(0, i, 2);
		end
		drv(4, 0, 0, 0, 0, 0);
		drv(2, 0, 0, 0, 0, 0);
		note(0, 7, 2);
		drv(0, 1, 3, 0, 0, 0);
		note(0, 3, 2);
		halt(0);
		bus(3, 0, 1, 0, 0, 4'h4, 0);
		halt(1);
		bus(0, 0, 1, 0, 0, 4'h1, 1);
		note(7, 1, 2);
		bus(0, 0, 0, 0, 0, 4'h0, 1);
		bus(2, 0, 0, 0, 0, 4'h3, 1);
		bus(6, 0, 0, 0, 0, 4'h7, 1);
		bus(1, 0, 0, 0, 0, 4'h2, 1);
		bus(3, 0, 1, 0, 0, 4'h4, 1);
		bus(4, 0, 1, 0, 1, 4'h5, 0);
		bus(0, 0, 0, 1, 0, 4'h1, 1);
		bus(0, 0, 1, 0, 1, 4'h1, 1);
		for (i = 0; i < 7; i++)
			bus(5, 3'(i), 1, 0, i == 3, i ? 4'(7 + i) : 4'h6, i != 3);
		for (i = 0; i < 2; i++)
		begin
			drv(1, 0, 0, 0, 0, 0);
			sync_flag <= !sync_flag;
			note(0, 1, 2);
			drv(0, 0, 0, 0, 0, 0);
			note(0, 3, 2);
			bus(3, 0, 1, 0, 0, 4'h4, 0);
			note(7, 2 + i, 2);
		end
		apb(0, 12'h000, 0, 0, 0);
		apb(0, 12'h010, 0, 0, 1);
		apb(1, 12'h000, 3, 0, 0);
		apb(0, 12'h000, 0, 3, 0);
		apb(0, 12'h004, 0, 32'h0000_0001, 0);
		fetch(1, 0, 0);
		fetch(0, 1, 1);
		repeat (4) @(posedge pclk);
		chk("pending", notes.size(), 0);
		summarize();
	end
endmodule
